// >>> rtl/spsf_top.sv
`default_nettype none
module spsf_top (
   input wire logic mclk_in, // System clock
   input wire logic rst_in, // Sync reset, high
   input wire logic [spsf_pkg::AW-1:0] avs_address_in, // Byte address
   input wire logic avs_read_in, // Read request
   input wire logic avs_write_in, // Write request
   input wire logic [spsf_pkg::DW-1:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Byte lanes
   output logic [spsf_pkg::DW-1:0] avs_readdata_out, // Read data
   output logic avs_waitrequest_out, // Slave stall
   input wire logic [spsf_pkg::CHN-1:0] cts_pin_in, // CTS pins
   input wire logic [spsf_pkg::CHN-1:0][spsf_pkg::CW-1:0]
      rx_count_in, // Receive fill
   input wire logic [spsf_pkg::CHN-1:0] head_brk_in, // Head break tag
   input wire logic [spsf_pkg::CHN-1:0] head_fe_in, // Head frame tag
   input wire logic [spsf_pkg::CHN-1:0] head_pe_in, // Head parity tag
   input wire logic [spsf_pkg::CHN-1:0] head_oe_in, // Head overrun tag
   input wire logic [spsf_pkg::CHN-1:0] rx_pop_in, // Data port read
   input wire logic [spsf_pkg::CHN-1:0] rx_err_det_in, // Any rx error
   input wire logic [spsf_pkg::CHN-1:0] rx_ovr_det_in, // Overrun seen
   input wire logic [spsf_pkg::CHN-1:0] rx_timeout_in, // Rx time-out
   input wire logic [spsf_pkg::CHN-1:0] brk_det_in, // Break frame
   input wire logic [spsf_pkg::CHN-1:0] nonbrk_frame_in, // Normal frame
   input wire logic [spsf_pkg::CHN-1:0][spsf_pkg::CW-1:0]
      tx_free_in, // Free tx entries
   input wire logic [spsf_pkg::CHN-1:0] tx_shift_empty_in, // Shifters idle
   input wire logic [spsf_pkg::CHN-1:0][1:0]
      rx_trigger_level_in, // Rx trigger code
   input wire logic [spsf_pkg::CHN-1:0][1:0]
      tx_trigger_level_in, // Tx trigger code
   input wire logic [spsf_pkg::CHN-1:0][spsf_pkg::SEL_W-1:0]
      status_change_select_in, // Summary sources
   input wire logic [spsf_pkg::CHN-1:0][1:0]
      cts_edge_select_in, // CTS edge choice
   output logic [spsf_pkg::CHN-1:0] tx_level_request_out, // Tx request
   output logic [spsf_pkg::CHN-1:0] rx_level_request_out, // Rx request
   output logic [spsf_pkg::CHN-1:0] status_change_summary_out // Summary
);
   import spsf_pkg::*;

   spsf_state_s s_q, s_d;
   logic [CHN-1:0] cts_lvl;
   logic req;
   logic wr_now;
   logic [DW-1:0] bemask;
   logic [CHN-1:0][DW-1:0] dis_rd;
   logic [CHN-1:0][DW-1:0] sc_rd;
   logic [CHN-1:0][DW-1:0] dis_clr;
   logic [CHN-1:0][DW-1:0] sc_clr;

   // Bus handshake: one wait cycle, write lands at completion
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~s_q.ack;
   assign wr_now = avs_write_in & s_q.ack;
   assign bemask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

   genvar g;
   generate
      for (g = 0; g < CHN; g++)
      begin : g_chan
         // CTS pin synchroniser
         spsf_sync u_cts (
            .mclk_in(mclk_in),
            .rst_in(rst_in),
            .pin_in(cts_pin_in[g]),
            .lvl_out(cts_lvl[g])
         );

         // Readback words, reserved bits zero
         assign dis_rd[g] = {16'h0000, s_q.ent_brk[g], s_q.rx_empty[g],
            s_q.ent_fe[g], s_q.ent_pe[g], s_q.ent_oe[g],
            s_q.rx_err_ev[g], s_q.rx_to_ev[g], s_q.tx_req[g],
            s_q.rx_req[g], s_q.status_change_summary[g], 1'b0, rx_count_in[g]};
         assign sc_rd[g] = {26'h0000000, s_q.ovr_ev[g], cts_lvl[g],
            s_q.live_brk[g], s_q.tx_free[g], s_q.all_sent[g],
            s_q.brk_seen[g]};

         // Clearing masks: only enabled lanes holding 0 clear
         assign dis_clr[g] = (wr_now && avs_address_in == DISR_ADDR[g]) ?
            (~avs_writedata_in & bemask) : '0;
         assign sc_clr[g] = (wr_now && avs_address_in == SCISR_ADDR[g]) ?
            (~avs_writedata_in & bemask) : '0;
      end
   endgenerate

   // Next state for bus and both channels
   always_comb
   begin
      logic rise;
      logic fall;
      logic cts_ev;
      logic load;
      logic [SEL_W-1:0] src;
      rise = 1'b0;
      fall = 1'b0;
      cts_ev = 1'b0;
      load = 1'b0;
      src = '0;
      s_d = s_q;
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack)
      begin
         s_d.rdata = '0;
         for (int c = 0; c < CHN; c++)
         begin
            if (avs_address_in == DISR_ADDR[c])
            begin
               s_d.rdata = dis_rd[c];
            end
            if (avs_address_in == SCISR_ADDR[c])
            begin
               s_d.rdata = sc_rd[c];
            end
         end
      end
      for (int c = 0; c < CHN; c++)
      begin
         // Entry tags follow the head after each data port read
         s_d.pop_dly[c] = rx_pop_in[c];
         load = s_q.pop_dly[c] || rx_count_in[c] == '0 ||
                s_q.rx_empty[c];
         if (load)
         begin
            s_d.ent_brk[c] = head_brk_in[c] & (rx_count_in[c] != '0);
            s_d.ent_fe[c] = head_fe_in[c] & (rx_count_in[c] != '0);
            s_d.ent_pe[c] = head_pe_in[c] & (rx_count_in[c] != '0);
            s_d.ent_oe[c] = head_oe_in[c] & (rx_count_in[c] != '0);
         end
         // Live levels
         s_d.rx_empty[c] = rx_count_in[c] == '0;
         s_d.tx_free[c] = tx_free_in[c] != '0;
         s_d.all_sent[c] = tx_free_in[c] == TX_DEPTH &&
                           tx_shift_empty_in[c];
         // Sticky events, set beats clear
         s_d.rx_err_ev[c] = rx_err_det_in[c] |
            (s_q.rx_err_ev[c] & ~dis_clr[c][B_RX_ERR]);
         s_d.rx_to_ev[c] = rx_timeout_in[c] |
            (s_q.rx_to_ev[c] & ~dis_clr[c][B_RX_TO]);
         s_d.tx_req[c] =
            (tx_free_in[c] >= tx_trig(tx_trigger_level_in[c])) |
            (s_q.tx_req[c] & ~dis_clr[c][B_TX_REQ]);
         s_d.rx_req[c] =
            (rx_count_in[c] >= rx_trig(rx_trigger_level_in[c])) |
            (s_q.rx_req[c] & ~dis_clr[c][B_RX_REQ]);
         s_d.ovr_ev[c] = rx_ovr_det_in[c] |
            (s_q.ovr_ev[c] & ~sc_clr[c][B_OVR]);
         s_d.brk_seen[c] = brk_det_in[c] |
            (s_q.brk_seen[c] & ~sc_clr[c][B_SEEN]);
         // Live break: set by break, dropped by a normal frame
         if (brk_det_in[c])
         begin
            s_d.live_brk[c] = 1'b1;
         end
         else if (nonbrk_frame_in[c])
         begin
            s_d.live_brk[c] = 1'b0;
         end
         // CTS edge per select code
         s_d.cts_prev[c] = cts_lvl[c];
         rise = cts_lvl[c] & ~s_q.cts_prev[c];
         fall = ~cts_lvl[c] & s_q.cts_prev[c];
         cts_ev = (cts_edge_select_in[c] == CTS_RISE && rise) ||
                  (cts_edge_select_in[c] == CTS_FALL && fall) ||
                  (cts_edge_select_in[c] == CTS_BOTH && (rise || fall));
         // Summary sources; overrun as level, CTS on its selected edge, others on rising
         src = '0;
         src[B_OVR] = s_d.ovr_ev[c];
         src[B_CTS] = cts_ev;
         src[B_LIVE] = s_d.live_brk[c] & ~s_q.live_brk[c];
         src[B_TXFREE] = s_d.tx_free[c] & ~s_q.tx_free[c];
         src[B_ALLSENT] = s_d.all_sent[c] & ~s_q.all_sent[c];
         src[B_SEEN] = s_d.brk_seen[c] & ~s_q.brk_seen[c];
         s_d.status_change_summary[c] = |(src & status_change_select_in[c]) |
            (s_q.status_change_summary[c] & ~dis_clr[c][B_STATUS_CHANGE_SUMMARY]);
      end
   end

   // State register
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         s_q <= STATE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs from flops
   assign avs_readdata_out = s_q.rdata;
   assign tx_level_request_out = s_q.tx_req;
   assign rx_level_request_out = s_q.rx_req;
   assign status_change_summary_out = s_q.status_change_summary;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   // Per-channel checks and coverage
   generate
      for (g = 0; g < CHN; g++)
      begin : g_chk
         chk_entry_brk: assert property (
            s_q.pop_dly[g] && rx_count_in[g] != '0
            |=> s_q.ent_brk[g] == $past(head_brk_in[g]))
            else $error("entry break tag not refreshed");
         chk_entry_fe: assert property (
            s_q.pop_dly[g] && rx_count_in[g] != '0
            |=> s_q.ent_fe[g] == $past(head_fe_in[g]))
            else $error("entry frame tag not refreshed");
         chk_rx_empty: assert property (
            rx_count_in[g] != '0 |=> !s_q.rx_empty[g])
            else $error("empty indicator set while data held");
         chk_err_hold: assert property (
            s_q.rx_err_ev[g] && !dis_clr[g][B_RX_ERR] |=> s_q.rx_err_ev[g])
            else $error("error event lost without clear");
         chk_set_wins: assert property (
            rx_timeout_in[g] && dis_clr[g][B_RX_TO] |=> s_q.rx_to_ev[g])
            else $error("time-out lost to same-cycle clear");
         chk_rx_req: assert property (
            rx_count_in[g] >= rx_trig(rx_trigger_level_in[g])
            |=> s_q.rx_req[g])
            else $error("receive request not set at level");
         chk_tx_req: assert property (
            tx_free_in[g] >= tx_trig(tx_trigger_level_in[g])
            |=> s_q.tx_req[g])
            else $error("transmit request not set at level");
         chk_cts_level: assert property (
            cts_pin_in[g] [*5] |-> cts_lvl[g])
            else $error("cts level not followed");
         chk_live_break: assert property (
            nonbrk_frame_in[g] && !brk_det_in[g] |=> !s_q.live_brk[g])
            else $error("live break not cleared by frame");
         chk_seen_sticky: assert property (
            brk_det_in[g] ##1 !sc_clr[g][B_SEEN] |=> s_q.brk_seen[g])
            else $error("sticky break not held");
         // Entry tags after a data port read
         chk_entry_pe: assert property (
            s_q.pop_dly[g] && rx_count_in[g] != '0
            |=> s_q.ent_pe[g] == $past(head_pe_in[g]))
            else $error("entry parity tag not refreshed");
         chk_entry_oe: assert property (
            s_q.pop_dly[g] && rx_count_in[g] != '0
            |=> s_q.ent_oe[g] == $past(head_oe_in[g]))
            else $error("entry overrun tag not refreshed");
         chk_rx_empty_set: assert property (
            rx_count_in[g] == '0 |=> s_q.rx_empty[g])
            else $error("empty indicator clear while empty");
         // Event flags set at once and clear on a written 0
         chk_err_set: assert property (
            rx_err_det_in[g] |=> s_q.rx_err_ev[g])
            else $error("error event not set");
         chk_err_clear: assert property (
            s_q.rx_err_ev[g] && dis_clr[g][B_RX_ERR] && !rx_err_det_in[g]
            |=> !s_q.rx_err_ev[g])
            else $error("error event not cleared");
         chk_to_set: assert property (
            rx_timeout_in[g] |=> s_q.rx_to_ev[g])
            else $error("time-out event not set");
         chk_to_clear: assert property (
            s_q.rx_to_ev[g] && dis_clr[g][B_RX_TO] && !rx_timeout_in[g]
            |=> !s_q.rx_to_ev[g])
            else $error("time-out event not cleared");
         chk_ovr_set: assert property (
            rx_ovr_det_in[g] |=> s_q.ovr_ev[g])
            else $error("overrun event not set");
         chk_ovr_hold: assert property (
            s_q.ovr_ev[g] && !sc_clr[g][B_OVR] |=> s_q.ovr_ev[g])
            else $error("overrun event lost without clear");
         // Live transmit levels and break state
         chk_tx_space: assert property (
            tx_free_in[g] != '0 |=> s_q.tx_free[g])
            else $error("transmit ready low with space free");
         chk_tx_full: assert property (
            tx_free_in[g] == '0 |=> !s_q.tx_free[g])
            else $error("transmit ready high with no space");
         chk_sent_set: assert property (
            tx_free_in[g] == TX_DEPTH && tx_shift_empty_in[g]
            |=> s_q.all_sent[g])
            else $error("all-sent low while idle");
         chk_sent_busy: assert property (
            !(tx_free_in[g] == TX_DEPTH && tx_shift_empty_in[g])
            |=> !s_q.all_sent[g])
            else $error("all-sent high while busy");
         chk_live_set: assert property (
            brk_det_in[g] |=> s_q.live_brk[g])
            else $error("live break not set");
         chk_seen_set: assert property (
            brk_det_in[g] |=> s_q.brk_seen[g])
            else $error("sticky break not set");
         // Summary bit behaviour
         chk_status_change_summary_hold: assert property (
            s_q.status_change_summary[g] && !dis_clr[g][B_STATUS_CHANGE_SUMMARY] |=> s_q.status_change_summary[g])
            else $error("summary lost without clear");
         chk_status_change_summary_quiet: assert property (
            status_change_select_in[g] == '0 && !s_q.status_change_summary[g]
            |=> !s_q.status_change_summary[g])
            else $error("summary set with no source selected");
         chk_status_change_summary_ovr: assert property (
            status_change_select_in[g][B_OVR] && rx_ovr_det_in[g]
            |=> s_q.status_change_summary[g])
            else $error("summary not set by selected overrun");
         cov_pop: cover property (rx_pop_in[g] ##2 s_q.ent_brk[g]);
         cov_status_change_summary: cover property (!s_q.status_change_summary[g] ##1 s_q.status_change_summary[g]);
         cov_clear: cover property (s_q.rx_err_ev[g] ##1 !s_q.rx_err_ev[g]);
      end
   endgenerate

   cov_read: cover property (avs_read_in && !avs_waitrequest_out);

   // Every request is answered after exactly one wait cycle
   chk_bus_wait: assert property (
      (avs_read_in || avs_write_in) && !s_q.ack |=> !avs_waitrequest_out)
      else $error("bus wait longer than one cycle");
endmodule // spsf_top
`default_nettype wire

// >>> common/spsf_pkg.sv
`default_nettype none
package spsf_pkg;
   // Channel count and bus geometry
   localparam int CHN = 2;
   localparam int AW = 16;
   localparam int DW = 32;
   localparam int CW = 5;
   localparam logic [CW-1:0] TX_DEPTH = 5'h10;

   // Register byte addresses, one per channel
   localparam logic [CHN-1:0][AW-1:0] DISR_ADDR = {16'hf408, 16'hf308};
   localparam logic [CHN-1:0][AW-1:0] SCISR_ADDR = {16'hf40c, 16'hf30c};

   // DMA/interrupt status register fields
   localparam int B_ENT_BRK = 15;
   localparam int B_RX_EMPTY = 14;
   localparam int B_ENT_FE = 13;
   localparam int B_ENT_PE = 12;
   localparam int B_ENT_OE = 11;
   localparam int B_RX_ERR = 10;
   localparam int B_RX_TO = 9;
   localparam int B_TX_REQ = 8;
   localparam int B_RX_REQ = 7;
   localparam int B_STATUS_CHANGE_SUMMARY = 6;
   localparam int B_CNT_HI = 4;

   // Status change register fields, also the select field layout
   localparam int B_OVR = 5;
   localparam int B_CTS = 4;
   localparam int B_LIVE = 3;
   localparam int B_TXFREE = 2;
   localparam int B_ALLSENT = 1;
   localparam int B_SEEN = 0;
   localparam int SEL_W = 6;

   // CTS edge select codes
   localparam logic [1:0] CTS_RISE = 2'h1;
   localparam logic [1:0] CTS_FALL = 2'h2;
   localparam logic [1:0] CTS_BOTH = 2'h3;

   // Trigger level codes and byte counts
   localparam logic [1:0] TRIG_C1 = 2'h0;
   localparam logic [1:0] TRIG_C4 = 2'h1;
   localparam logic [1:0] TRIG_C8 = 2'h2;
   localparam logic [CW-1:0] LVL_1 = 5'h01;
   localparam logic [CW-1:0] LVL_4 = 5'h04;
   localparam logic [CW-1:0] LVL_8 = 5'h08;
   localparam logic [CW-1:0] LVL_12 = 5'h0c;

   // Receive trigger decode
   function automatic logic [CW-1:0] rx_trig(input logic [1:0] code);
      unique case (code)
         TRIG_C1: rx_trig = LVL_1;
         TRIG_C4: rx_trig = LVL_4;
         TRIG_C8: rx_trig = LVL_8;
         default: rx_trig = LVL_12;
      endcase
   endfunction

   // Transmit trigger decode, forbidden code acts as the largest level
   function automatic logic [CW-1:0] tx_trig(input logic [1:0] code);
      unique case (code)
         TRIG_C1: tx_trig = LVL_1;
         TRIG_C4: tx_trig = LVL_4;
         default: tx_trig = LVL_8;
      endcase
   endfunction

   // Flag block state
   typedef struct packed {
      logic ack;
      logic [DW-1:0] rdata;
      logic [CHN-1:0] ent_brk;
      logic [CHN-1:0] ent_fe;
      logic [CHN-1:0] ent_pe;
      logic [CHN-1:0] ent_oe;
      logic [CHN-1:0] pop_dly;
      logic [CHN-1:0] rx_err_ev;
      logic [CHN-1:0] rx_to_ev;
      logic [CHN-1:0] tx_req;
      logic [CHN-1:0] rx_req;
      logic [CHN-1:0] status_change_summary;
      logic [CHN-1:0] ovr_ev;
      logic [CHN-1:0] live_brk;
      logic [CHN-1:0] brk_seen;
      logic [CHN-1:0] rx_empty;
      logic [CHN-1:0] tx_free;
      logic [CHN-1:0] all_sent;
      logic [CHN-1:0] cts_prev;
   } spsf_state_s;

   localparam spsf_state_s STATE_RST = '{tx_req: '1, rx_empty: '1,
      tx_free: '1, all_sent: '1, default: '0};

   // Pin synchroniser state
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } spsf_sync_s;
endpackage
`default_nettype wire

// >>> rtl/spsf_sync.sv
`default_nettype none
module spsf_sync (
   input wire logic mclk_in, // System clock
   input wire logic rst_in, // Sync reset, high
   input wire logic pin_in, // Asynchronous pin
   output logic lvl_out // Filtered level
);
   import spsf_pkg::*;

   spsf_sync_s s_q, s_d;

   // Three stages; level moves once stages two and three agree
   always_comb
   begin
      s_d = s_q;
      s_d.s1 = pin_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      if (s_q.s2 == s_q.s3)
      begin
         s_d.lvl = s_q.s3;
      end
   end

   // State register
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign lvl_out = s_q.lvl;
endmodule // spsf_sync
`default_nettype wire

// >>> verif/spsf_peer.sv
`default_nettype none
module spsf_peer (
   input wire logic mclk_in, // System clock
   output logic [spsf_pkg::CHN-1:0][spsf_pkg::CW-1:0] cnt_out, // Fill
   output logic [spsf_pkg::CHN-1:0][3:0] head_out, // Tags brk,fe,pe,oe
   output logic [spsf_pkg::CHN-1:0] pop_out, // Data port read
   output logic [spsf_pkg::CHN-1:0] err_out, // Error pulse
   output logic [spsf_pkg::CHN-1:0] ovr_out, // Overrun pulse
   output logic [spsf_pkg::CHN-1:0] brk_out, // Break frame pulse
   output logic [spsf_pkg::CHN-1:0] frm_out // Normal frame pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   import spsf_pkg::*;
   logic [3:0] q[CHN][$]; // Stored entries per channel
   // Quiet line, empty FIFO
   initial
   begin
      {cnt_out, head_out, pop_out, err_out, ovr_out, brk_out, frm_out} = '0;
   end
   // Present fill and head tags, zero when empty
   task automatic show(input int ch);
      cnt_out[ch] <= CW'(q[ch].size());
      head_out[ch] <= (q[ch].size() > 0) ? q[ch][0] : 4'h0;
   endtask
   // Refill with clean entries
   task automatic fill(input int ch, input int n);
      @(posedge mclk_in);
      q[ch].delete();
      repeat (n) q[ch].push_back(4'h0);
      show(ch);
   endtask
   // One frame arrives with its tags and event pulses
   task automatic frame(input int ch, input logic [3:0] t);
      @(posedge mclk_in);
      q[ch].push_back(t);
      show(ch);
      {err_out[ch], ovr_out[ch], brk_out[ch], frm_out[ch]} <=
         {|t[2:0], t[0], t[3], ~t[3]};
      @(posedge mclk_in);
      {err_out[ch], ovr_out[ch], brk_out[ch], frm_out[ch]} <= 4'h0;
   endtask
   // Software read of the data port advances the head
   task automatic pop(input int ch);
      @(posedge mclk_in);
      void'(q[ch].pop_front());
      show(ch);
      pop_out[ch] <= 1'b1;
      @(posedge mclk_in);
      pop_out[ch] <= 1'b0;
   endtask
endmodule // spsf_peer
`default_nettype wire

// >>> verif/spsf_top_bench.sv
`default_nettype none
module spsf_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import spsf_pkg::*;
   // Row: rx code, fill, tx code, free, expected rx and tx requests
   typedef struct packed {
      logic [1:0] rc;
      logic [CW-1:0] n;
      logic [1:0] tc;
      logic [CW-1:0] tf;
      logic rx;
      logic tx;
   } spsf_row_s;
   localparam spsf_row_s ROWS[9] = '{
      '{2'h0, 5'h00, 2'h0, 5'h00, 1'h0, 1'h0},
      '{2'h0, 5'h01, 2'h0, 5'h01, 1'h1, 1'h1},
      '{2'h1, 5'h03, 2'h1, 5'h03, 1'h0, 1'h0},
      '{2'h1, 5'h04, 2'h1, 5'h04, 1'h1, 1'h1},
      '{2'h2, 5'h07, 2'h2, 5'h07, 1'h0, 1'h0},
      '{2'h2, 5'h08, 2'h2, 5'h08, 1'h1, 1'h1},
      '{2'h3, 5'h0b, 2'h3, 5'h07, 1'h0, 1'h0},
      '{2'h3, 5'h0c, 2'h3, 5'h08, 1'h1, 1'h1},
      '{2'h3, 5'h10, 2'h0, 5'h10, 1'h1, 1'h1}};
   logic mclk_in, rst_in, rd, wr, waitreq;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata, rdata, got;
   logic [3:0] be;
   logic [CHN-1:0] cts, she, to, txq, rxq, sum, pop, err, ovr, brk, frm;
   logic [CHN-1:0][CW-1:0] cnt, txf;
   logic [CHN-1:0][3:0] head;
   logic [CHN-1:0][1:0] rtl, ttl, ces;
   logic [CHN-1:0][SEL_W-1:0] sel;
   int errors, samples_checked, cyc;
   // Far side of the receive path
   spsf_peer peer (
      .mclk_in(mclk_in), .cnt_out(cnt), .head_out(head), .pop_out(pop),
      .err_out(err), .ovr_out(ovr), .brk_out(brk), .frm_out(frm)
   );
   // Block under test
   spsf_top uut (
      .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .cts_pin_in(cts), .rx_count_in(cnt),
      .head_brk_in({head[1][3], head[0][3]}),
      .head_fe_in({head[1][2], head[0][2]}),
      .head_pe_in({head[1][1], head[0][1]}),
      .head_oe_in({head[1][0], head[0][0]}),
      .rx_pop_in(pop), .rx_err_det_in(err), .rx_ovr_det_in(ovr),
      .rx_timeout_in(to), .brk_det_in(brk), .nonbrk_frame_in(frm),
      .tx_free_in(txf), .tx_shift_empty_in(she),
      .rx_trigger_level_in(rtl), .tx_trigger_level_in(ttl),
      .status_change_select_in(sel), .cts_edge_select_in(ces),
      .tx_level_request_out(txq), .rx_level_request_out(rxq),
      .status_change_summary_out(sum)
   );
   // Clock
   initial
   begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   // Verdict and end of run
   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Cycle ceiling against hangs
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         errors++;
         $display("[ERR] %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Compare and count
   task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Bus cycle held until waitrequest is seen low
   task automatic bus(input logic w, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
      @(posedge mclk_in);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do
         @(posedge mclk_in);
      while (waitreq !== 1'b0);
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
      bus(1'b0, a, '0);
      chk(got, e);
   endtask
   // Main sequence
   initial
   begin
      {errors, samples_checked, cyc} = '0;
      {rd, wr, to, cts, rtl, ttl, ces, sel, addr, wdata} = '0;
      be = 4'hf;
      she = '1;
      txf = {CHN{TX_DEPTH}};
      rst_in = 1'b1;
      tick(10);
      rst_in <= 1'b0;
      rdchk(DISR_ADDR[0], 32'h0000_4100);
      rdchk(SCISR_ADDR[1], 32'h0000_0006);
      chk({sum, rxq, txq}, 6'h03);
      rdchk(16'hf310, 32'h0);
      for (int c = 0; c < CHN; c++)
      begin
         foreach (ROWS[i])
         begin
            @(posedge mclk_in);
            rtl[c] <= ROWS[i].rc;
            ttl[c] <= ROWS[i].tc;
            txf[c] <= ROWS[i].tf;
            peer.fill(c, int'(ROWS[i].n));
            tick(3);
            bus(1'b1, DISR_ADDR[c], 32'hffff_fe7f);
            tick(3);
            chk({rxq[c], txq[c]}, {ROWS[i].rx, ROWS[i].tx});
            rdchk(DISR_ADDR[c], {17'h0, ROWS[i].n == 5'h0, 5'h0,
               ROWS[i].tx, ROWS[i].rx, 2'h0, ROWS[i].n});
         end
         peer.fill(c, 0);
      end
      // Events, entry tags and clearing writes
      @(posedge mclk_in);
      rtl[0] <= TRIG_C1;
      peer.frame(0, 4'h8);
      rdchk(SCISR_ADDR[0], 32'h0000_000f);
      peer.frame(0, 4'h4);
      peer.frame(0, 4'h3);
      @(posedge mclk_in);
      to[0] <= 1'b1;
      @(posedge mclk_in);
      to[0] <= 1'b0;
      rdchk(SCISR_ADDR[0], 32'h0000_0027);
      rdchk(DISR_ADDR[0], 32'h0000_8783);
      bus(1'b1, DISR_ADDR[0], '1);
      bus(1'b1, SCISR_ADDR[0], '1);
      rdchk(SCISR_ADDR[0], 32'h0000_0027);
      bus(1'b1, DISR_ADDR[0], 32'hffff_fbff);
      rdchk(DISR_ADDR[0], 32'h0000_8383);
      @(posedge mclk_in);
      to[0] <= 1'b1;
      bus(1'b1, DISR_ADDR[0], 32'hffff_fdff);
      to[0] <= 1'b0;
      rdchk(DISR_ADDR[0], 32'h0000_8383);
      bus(1'b1, DISR_ADDR[0], 32'hffff_fdff);
      rdchk(DISR_ADDR[0], 32'h0000_8183);
      peer.pop(0);
      rdchk(DISR_ADDR[0], 32'h0000_2182);
      peer.pop(0);
      rdchk(DISR_ADDR[0], 32'h0000_1981);
      peer.pop(0);
      rdchk(DISR_ADDR[0], 32'h0000_4180);
      bus(1'b1, SCISR_ADDR[0], '0);
      rdchk(SCISR_ADDR[0], 32'h0000_0006);
      // Each summary source selected alone
      for (int b = 0; b < SEL_W; b++)
      begin
         @(posedge mclk_in);
         {sel[0], cts[0], txf[0], she[0]} <= '0;
         ces[0] <= CTS_RISE;
         peer.frame(0, 4'h0);
         tick(8);
         bus(1'b1, SCISR_ADDR[0], '0);
         bus(1'b1, DISR_ADDR[0], '0);
         @(posedge mclk_in);
         sel[0] <= SEL_W'(1 << b);
         tick(4);
         chk(sum[0], 1'b0);
         @(posedge mclk_in);
         txf[0] <= (b == 1 || b == 2) ? TX_DEPTH : 5'h00;
         she[0] <= (b == 1);
         cts[0] <= (b == 4);
         if (b == 0 || b == 3)
            peer.frame(0, 4'h8);
         if (b == 5)
            peer.frame(0, 4'h1);
         tick(12);
         chk(sum[0], 1'b1);
      end
      @(posedge mclk_in);
      cts[0] <= 1'b1;
      tick(10);
      bus(1'b0, SCISR_ADDR[0], '0);
      chk(got & 32'h10, 32'h10);
      end_of_test();
   end
endmodule // spsf_top_bench
`default_nettype wire
